/* File: rtl/mfb_pkg.sv */
package mfb_pkg;

	// Fixed point: signed, FRAC fraction bits, 1.0 equals 100 percent
	localparam int                 FRAC     = 12;
	localparam int                 ONE_I    = 1 << FRAC;
	localparam logic signed [15:0] ONE      = 16'(ONE_I);
	localparam logic signed [15:0] HALF     = 16'(ONE_I / 2);
	localparam logic signed [15:0] ZERO     = 16'sh0000;

	// Register regions, address bits [7:4]; word index in bits [3:2]
	localparam logic [3:0]         REG_MIN   = 4'h0;
	localparam logic [3:0]         REG_MAX   = 4'h1;
	localparam logic [3:0]         REG_SCALE = 4'h2;
	localparam logic [3:0]         REG_SRC   = 4'h3;
	localparam logic [3:0]         REG_CTRL  = 4'h4;
	localparam logic [3:0]         REG_FN    = 4'h5;
	localparam logic [3:0]         REG_WGT   = 4'h6;

	// Words inside the control region
	localparam logic [1:0]         CTRL_OPS  = 2'h0;
	localparam logic [1:0]         CTRL_OMIN = 2'h1;
	localparam logic [1:0]         CTRL_OMAX = 2'h2;
	localparam logic [1:0]         CTRL_OUT  = 2'h3;

	// Input source field layout
	localparam int                 SRC_LSB   = 0;
	localparam int                 FNUM_LSB  = 2;
	localparam logic [1:0]         SRC_UNUSED = 2'h0;
	localparam logic [1:0]         SRC_EXT    = 2'h1;
	localparam logic [1:0]         SRC_SELF   = 2'h2;

	// Operator field width inside the operator word
	localparam int                 OP_W      = 4;

	// Reset values
	localparam logic signed [15:0] RST_MIN   = 16'sh0000;
	localparam logic signed [15:0] RST_MAX   = 16'sh1000;
	localparam logic signed [15:0] RST_SCALE = 16'sh1000;
	localparam logic [3:0]         RST_SRC   = 4'h1;
	localparam logic [11:0]        RST_OPS   = 12'h999;
	localparam logic signed [15:0] RST_OMIN  = 16'sh0000;
	localparam logic signed [15:0] RST_OMAX  = 16'sh1000;

	typedef enum logic [3:0] {
		OP_EQ  = 4'h0,
		OP_NE  = 4'h1,
		OP_GT  = 4'h2,
		OP_GE  = 4'h3,
		OP_LT  = 4'h4,
		OP_LE  = 4'h5,
		OP_OR  = 4'h6,
		OP_AND = 4'h7,
		OP_XOR = 4'h8,
		OP_ADD = 4'h9,
		OP_SUB = 4'ha,
		OP_MUL = 4'hb,
		OP_DIV = 4'hc,
		OP_MIN = 4'hd,
		OP_MAX = 4'he
	} mfb_op_type;

	typedef struct packed {
		logic                err;
		logic signed [15:0]  val;
	} mfb_in_type;

endpackage

/* File: rtl/mfb_math_block.sv */
// What this block does
// [RL1] Four inputs, each with own settings
// [RL2] Inputs become percent of min-max span
// [RL3] Weight per input, default 1.0, range -1.0 to 1.0
// [RL4] Codes 0-5 compare operands in order
// [RL5] Codes 6-8 are OR, AND, XOR
// [RL6] Codes 9-14 sum, difference, product, quotient, min, max
// [RL7] Three functions chained over inputs one to four
// [RL8] Self source feeds function result or output
// [RL9] Intermediate results stay inside this block
// [RL10] Unused input skips its consuming function; code skips only for inputs two to four, unused input one enters as zero
// [RL11] Logical truth means weighted input at least half
// [RL12] Compare and logic results are 0 or 1
// [RL13] Erroneous input enters as zero
// [RL14] Zero divisor gives zero result
// [RL15] Negative difference clamps to zero
// [RL16] Result mapped to output min and max
// [RL17] Software keeps arithmetic inside full scale
// [RL18] Percent conversion clamps to 0 and 100
//
// Our own choices: the Avalon-MM slave port and the register offsets.
module mfb_math_block (
	input  wire  logic                        clk_sys,
	input  wire  logic                        rst,
	input  wire  logic                        ce,
	input  wire  mfb_pkg::mfb_in_type [3:0]   src_in,
	input  wire  logic [7:0]                  avs_address,
	input  wire  logic                        avs_read,
	input  wire  logic                        avs_write,
	input  wire  logic [31:0]                 avs_writedata,
	output logic [31:0]                       avs_readdata,
	output logic                              avs_waitrequest,
	output logic signed [15:0]                out_value,
	output logic signed [15:0]                out_min,
	output logic signed [15:0]                out_max
);
	import mfb_pkg::*;

	logic signed [15:0] min_q   [4];
	logic signed [15:0] max_q   [4];
	logic signed [15:0] scale_q [4];
	logic [3:0]         src_q   [4];
	logic [11:0]        ops_q;
	logic signed [15:0] omin_q;
	logic signed [15:0] omax_q;
	logic signed [15:0] w_q     [4];
	logic signed [15:0] fn_q    [3];
	logic signed [15:0] pct_q;
	logic signed [15:0] out_q;
	logic               wait_q;
	logic [31:0]        rdata_q;

	logic signed [15:0] w_d     [4];
	logic               used    [4];
	logic signed [15:0] fn_d    [3];
	logic signed [15:0] out_d;
	logic [31:0]        rd_d;
	logic signed [15:0] wr_s;
	logic [1:0]         idx;

	assign avs_waitrequest = wait_q;
	assign avs_readdata    = rdata_q;
	assign out_value       = out_q;
	assign out_min         = omin_q;
	assign out_max         = omax_q;
	assign idx             = avs_address[3:2];
	assign wr_s            = avs_writedata[15:0];

	function automatic logic signed [15:0] sat(input logic signed [31:0] v);
		if (v > 32'(ONE))
			sat = ONE;
		else if (v < -32'(ONE))
			sat = -ONE;
		else
			sat = v[15:0];
	endfunction

	// [RL2] [RL18] Percent of span, clamped
	function automatic logic signed [15:0] norm(input logic signed [15:0] x, input logic signed [15:0] mn,
		input logic signed [15:0] mx);
		logic signed [31:0] num;
		logic signed [31:0] den;
		num = 32'(x) - 32'(mn);
		den = 32'(mx) - 32'(mn);
		if (den <= 0)
			norm = (x >= mx) ? ONE : ZERO;
		else if (num <= 0)
			norm = ZERO;
		else if (num >= den)
			norm = ONE;
		else
			norm = 16'((num <<< FRAC) / den);
	endfunction

	function automatic logic signed [15:0] bool(input logic b);
		bool = b ? ONE : ZERO;
	endfunction

	// [RL4] [RL5] [RL6] Two-operand function
	function automatic logic signed [15:0] calc(input logic [3:0] op, input logic signed [15:0] operand_a,
		input logic signed [15:0] operand_b);
		logic               ta;
		logic               tb;
		logic signed [31:0] d;
		// [RL11] Truth threshold
		ta = operand_a >= HALF;
		tb = operand_b >= HALF;
		d  = 32'(operand_a) - 32'(operand_b);
		// [RL12] Boolean results are 0 or 1
		case (op)
			OP_EQ:   calc = bool(operand_a == operand_b);
			OP_NE:   calc = bool(operand_a != operand_b);
			OP_GT:   calc = bool(operand_a > operand_b);
			OP_GE:   calc = bool(operand_a >= operand_b);
			OP_LT:   calc = bool(operand_a < operand_b);
			OP_LE:   calc = bool(operand_a <= operand_b);
			OP_OR:   calc = bool(ta | tb);
			OP_AND:  calc = bool(ta & tb);
			OP_XOR:  calc = bool(ta ^ tb);
			OP_ADD:  calc = sat(32'(operand_a) + 32'(operand_b));
			// [RL15] Negative difference clamps
			OP_SUB:  calc = (d < 0) ? ZERO : sat(d);
			OP_MUL:  calc = sat((32'(operand_a) * 32'(operand_b)) >>> FRAC);
			// [RL14] Zero divisor gives zero
			OP_DIV:  calc = (operand_b == ZERO) ? ZERO : sat((32'(operand_a) <<< FRAC) / 32'(operand_b));
			OP_MIN:  calc = (operand_a < operand_b) ? operand_a : operand_b;
			OP_MAX:  calc = (operand_a > operand_b) ? operand_a : operand_b;
			default: calc = ZERO;
		endcase
	endfunction

	// Input selection, normalising and weighting
	always_comb begin
		logic signed [15:0] p;
		logic [1:0]         fnum;
		p    = ZERO;
		fnum = 2'h0;
		for (int i = 0; i < 4; i++) begin
			// [RL1] Per-input source
			used[i] = src_q[i][SRC_LSB +: 2] != SRC_UNUSED;
			fnum    = src_q[i][FNUM_LSB +: 2];
			case (src_q[i][SRC_LSB +: 2])
				// [RL13] Error input is zero
				SRC_EXT:  p = src_in[i].err ? ZERO : norm(src_in[i].val, min_q[i], max_q[i]);
				// [RL8] [RL9] Own results feed back
				SRC_SELF: p = (fnum == 2'h0) ? pct_q : fn_q[fnum - 2'h1];
				default:  p = ZERO;
			endcase
			// [RL3] Weighting
			w_d[i] = sat((32'(p) * 32'(scale_q[i])) >>> FRAC);
		end
	end

	// [RL7] [RL10] Chain with skip on unused input
	always_comb begin
		logic signed [31:0] span;
		logic signed [15:0] pc;
		fn_d[0] = used[1] ? calc(ops_q[0 +: OP_W], w_d[0], w_d[1]) : w_d[0];
		fn_d[1] = used[2] ? calc(ops_q[OP_W +: OP_W], fn_d[0], w_d[2]) : fn_d[0];
		fn_d[2] = used[3] ? calc(ops_q[2 * OP_W +: OP_W], fn_d[1], w_d[3]) : fn_d[1];
		// [RL16] Map into output units
		pc    = (fn_d[2] < ZERO) ? ZERO : fn_d[2];
		span  = 32'(omax_q) - 32'(omin_q);
		out_d = 16'(32'(omin_q) + ((32'(pc) * span) >>> FRAC));
	end

	// Datapath registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++)
				w_q[i] <= ZERO;
			for (int i = 0; i < 3; i++)
				fn_q[i] <= ZERO;
			pct_q <= ZERO;
			out_q <= RST_OMIN;
		end else if (ce) begin
			for (int i = 0; i < 4; i++)
				w_q[i] <= w_d[i];
			for (int i = 0; i < 3; i++)
				fn_q[i] <= fn_d[i];
			pct_q <= fn_d[2];
			out_q <= out_d;
		end
	end

	// Read mux
	always_comb begin
		rd_d = 32'h0000_0000;
		case (avs_address[7:4])
			REG_MIN:   rd_d = {16'h0000, min_q[idx]};
			REG_MAX:   rd_d = {16'h0000, max_q[idx]};
			REG_SCALE: rd_d = {16'h0000, scale_q[idx]};
			REG_SRC:   rd_d = {28'h000_0000, src_q[idx]};
			REG_CTRL: begin
				case (idx)
					CTRL_OPS:  rd_d = {20'h0_0000, ops_q};
					CTRL_OMIN: rd_d = {16'h0000, omin_q};
					CTRL_OMAX: rd_d = {16'h0000, omax_q};
					default:   rd_d = {16'h0000, out_q};
				endcase
			end
			REG_FN:    rd_d = {16'h0000, (idx == 2'h3) ? pct_q : fn_q[idx]};
			REG_WGT:   rd_d = {16'h0000, w_q[idx]};
			default:   rd_d = 32'h0000_0000;
		endcase
	end

	// Bus slave and configuration registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				min_q[i]   <= RST_MIN;
				max_q[i]   <= RST_MAX;
				scale_q[i] <= RST_SCALE;
				src_q[i]   <= RST_SRC;
			end
			ops_q   <= RST_OPS;
			omin_q  <= RST_OMIN;
			omax_q  <= RST_OMAX;
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else if (ce) begin
			if ((avs_read || avs_write) && wait_q) begin
				wait_q <= 1'b0;
				if (avs_read)
					rdata_q <= rd_d;
				if (avs_write) begin
					case (avs_address[7:4])
						REG_MIN:   min_q[idx] <= wr_s;
						REG_MAX:   max_q[idx] <= wr_s;
						// [RL3] Weight limited to -1.0 to 1.0
						REG_SCALE: scale_q[idx] <= (wr_s > ONE) ? ONE : ((wr_s < -ONE) ? -ONE : wr_s);
						REG_SRC:   src_q[idx] <= avs_writedata[3:0];
						REG_CTRL: begin
							case (idx)
								CTRL_OPS:  ops_q <= avs_writedata[11:0];
								CTRL_OMIN: omin_q <= wr_s;
								CTRL_OMAX: omax_q <= wr_s;
								default:   ops_q <= ops_q;
							endcase
						end
						default:   ops_q <= ops_q;
					endcase
				end
			end else begin
				wait_q <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_req;
		ce && (avs_read || avs_write) && avs_waitrequest;
	endsequence

	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	AST_BUS_ACK: assert property (s_req |=> s_ack)
		else $error("bus request not answered in one cycle");

	AST_CMP_BOOL: assert property ( // [RL12]
		$past(ce && used[1] && ops_q[3:0] <= 4'h8) |-> (fn_q[0] == ZERO || fn_q[0] == ONE))
		else $error("boolean result not 0 or 1");

	AST_GT_RESULT: assert property ( // [RL4]
		$past(ce && used[1] && ops_q[3:0] == 4'h2) |-> (fn_q[0] == ONE) == $past(w_d[0] > w_d[1]))
		else $error("greater-than result wrong");

	AST_AND_TRUTH: assert property ( // [RL11]
		$past(ce && used[1] && ops_q[3:0] == 4'h7 && w_d[0] >= HALF && w_d[1] >= HALF) |-> fn_q[0] == ONE)
		else $error("AND of true operands not true");

	AST_SUB_NONNEG: assert property ( // [RL15]
		$past(ce && used[1] && ops_q[3:0] == 4'ha) |-> fn_q[0] >= ZERO)
		else $error("negative difference not clamped");

	AST_DIV_ZERO: assert property ( // [RL14]
		$past(ce && used[1] && ops_q[3:0] == 4'hc && w_d[1] == ZERO) |-> fn_q[0] == ZERO)
		else $error("divide by zero not zero");

	AST_SKIP_UNUSED: assert property ( // [RL10]
		$past(ce && !used[3]) |-> fn_q[2] == fn_q[1])
		else $error("unused input not skipped");

	AST_ERR_ZERO: assert property ( // [RL13]
		$past(ce && src_q[0][1:0] == SRC_EXT && src_in[0].err) |-> w_q[0] == ZERO)
		else $error("error input not zero");

	AST_NORM_RANGE: assert property ( // [RL18]
		$past(ce && src_q[0][1:0] == SRC_EXT && scale_q[0] == ONE) |-> (w_q[0] >= ZERO && w_q[0] <= ONE))
		else $error("percent out of range");

	AST_OUT_RANGE: assert property ( // [RL16]
		$past(ce && omin_q <= omax_q) && $stable(omin_q) && $stable(omax_q) |-> (out_q >= omin_q && out_q <= omax_q))
		else $error("output outside limits");

	AST_OUT_MAP: assert property ( // [RL16]
		$past(!rst && ce && fn_d[2] >= ZERO && omin_q == ZERO && omax_q == ONE) |-> out_q == $past(fn_d[2]))
		else $error("output not mapped from percent");

	AST_SELF_FN: assert property ( // [RL8]
		$past(!rst && ce && src_q[3] == {2'h1, SRC_SELF} && scale_q[3] == ONE) |-> w_q[3] == $past(fn_q[0]))
		else $error("function result not fed back");

	AST_SELF_OUT: assert property ( // [RL8]
		$past(!rst && ce && src_q[3] == {2'h0, SRC_SELF} && scale_q[3] == ONE) |-> w_q[3] == $past(pct_q))
		else $error("final percent not fed back");

	AST_SCALE_LIMIT: assert property ( // [RL3]
		scale_q[0] <= ONE && scale_q[0] >= -ONE)
		else $error("scaler outside limits");

endmodule

/* File: tb/mfb_src_model.sv */
module mfb_src_model (
	input  wire logic                      clk_sys,
	output mfb_pkg::mfb_in_type [3:0]      src_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import mfb_pkg::*;

	mfb_in_type [3:0] pend = '0;
	mfb_in_type [3:0] drive_q = '0;

	assign src_in = drive_q;

	// Values launch on the clock edge like a same-domain upstream block
	always @(posedge clk_sys)
		drive_q <= pend;

	// Upstream values capped at full scale from above
	task automatic put(input int idx, input logic signed [15:0] v, input logic e);
		pend[idx].val <= (v > ONE) ? ONE : v;
		pend[idx].err <= e;
	endtask
endmodule

/* File: tb/mfb_math_block_test.sv */
module mfb_math_block_test;
	timeunit 1ns;
	timeprecision 1ns;
	import mfb_pkg::*;

	logic               clk_sys;
	logic               rst;
	logic               ce;
	logic [7:0]         avs_address;
	logic               avs_read;
	logic               avs_write;
	logic [31:0]        avs_writedata;
	logic [31:0]        avs_readdata;
	logic [31:0]        rd;
	logic               avs_waitrequest;
	logic signed [15:0] out_value;
	logic signed [15:0] out_min;
	logic signed [15:0] out_max;
	mfb_in_type [3:0]   src_in;
	int                 fail_count;
	int                 checks;
	int                 pa[6] = '{32'h800, 32'h400, 32'h600, 32'h7f0, 32'h800, 32'hc00};
	int                 pb[6] = '{32'h400, 32'h800, 32'h600, 32'h800, 32'h000, 32'h800};

	mfb_src_model i_mfb_src_model (.clk_sys(clk_sys), .src_in(src_in));

	mfb_math_block i_mfb_math_block (.clk_sys(clk_sys), .rst(rst), .ce(ce), .src_in(src_in),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.out_value(out_value), .out_min(out_min), .out_max(out_max));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic conclude;
		if (fail_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic p(input int i, input logic signed [15:0] v, input logic e);
		i_mfb_src_model.put(i, v, e);
	endtask

	task automatic settle;
		repeat (8) @(posedge clk_sys);
	endtask

	// Expected function result for non-negative operands
	function automatic logic [31:0] expo(input int op, input int a, input int b);
		int r;
		case (op)
			0: r = ONE_I * (a == b);
			1: r = ONE_I * (a != b);
			2: r = ONE_I * (a > b);
			3: r = ONE_I * (a >= b);
			4: r = ONE_I * (a < b);
			5: r = ONE_I * (a <= b);
			6: r = ONE_I * (a >= HALF || b >= HALF);
			7: r = ONE_I * (a >= HALF && b >= HALF);
			8: r = ONE_I * ((a >= HALF) != (b >= HALF));
			9: r = a + b;
			10: r = (a > b) ? a - b : 0;
			11: r = (a * b) >>> FRAC;
			12: r = (b == 0) ? 0 : (a <<< FRAC) / b;
			13: r = (a < b) ? a : b;
			14: r = (a > b) ? a : b;
			default: r = 0;
		endcase
		if (r > ONE_I)
			r = ONE_I;
		return 32'(r);
	endfunction

	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		conclude;
	end

	initial begin
		fail_count = 0;
		checks = 0;
		rst = 1'b1;
		ce = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		settle;
		for (int i = 0; i < 4; i++) begin
			rc(8'h00 + 8'(4 * i), 32'h0);
			rc(8'h10 + 8'(4 * i), 32'h1000);
			rc(8'h20 + 8'(4 * i), 32'h1000);
			rc(8'h30 + 8'(4 * i), 32'h1);
		end
		rc(8'h40, 32'h999);
		rc(8'h48, 32'h1000);
		chk({16'h0, out_max}, 32'h1000);
		wr(8'h50, 32'h123);
		wr(8'h74, 32'h55);
		rc(8'h50, 32'h0);
		rc(8'h74, 32'h0);
		p(0, 16'h0800, 1'b0);
		p(1, 16'h0200, 1'b0);
		p(2, 16'h0100, 1'b0);
		p(3, 16'h0300, 1'b0);
		wr(8'h40, 32'h9aa);
		wr(8'h44, 32'h100);
		wr(8'h48, 32'h900);
		settle;
		rc(8'h50, 32'h600);
		rc(8'h54, 32'h500);
		rc(8'h58, 32'h800);
		rc(8'h4c, 32'h500);
		chk({16'h0, out_value}, 32'h500);
		chk({16'h0, out_min}, 32'h100);
		chk({16'h0, out_max}, 32'h900);
		wr(8'h44, 32'h0);
		wr(8'h48, 32'h1000);
		for (int i = 0; i < 3; i++)
			p(i, 16'h0100, 1'b0);
		wr(8'h3c, 32'h6);
		wr(8'h40, 32'h999);
		settle;
		rc(8'h58, 32'h500);
		wr(8'h3c, 32'h2);
		settle;
		rc(8'h58, 32'h1000);
		wr(8'h38, 32'h0);
		wr(8'h3c, 32'h0);
		for (int k = 0; k < 6; k++) begin
			p(0, 16'(pa[k]), 1'b0);
			p(1, 16'(pb[k]), 1'b0);
			for (int op = 0; op < 15; op++) begin
				wr(8'h40, {24'h99, 4'h9, 4'(op)});
				settle;
				rc(8'h50, expo(op, pa[k], pb[k]));
				chk({16'h0, out_value}, expo(op, pa[k], pb[k]));
			end
		end
		wr(8'h00, 32'h400);
		wr(8'h10, 32'hc00);
		p(0, 16'h0800, 1'b0);
		settle;
		rc(8'h60, 32'h800);
		p(0, 16'h0200, 1'b0);
		settle;
		rc(8'h60, 32'h0);
		p(0, 16'h0e00, 1'b0);
		settle;
		rc(8'h60, 32'h1000);
		p(0, 16'h0800, 1'b1);
		settle;
		rc(8'h60, 32'h0);
		p(0, 16'h0800, 1'b0);
		wr(8'h20, 32'hc00);
		settle;
		rc(8'h60, 32'h600);
		wr(8'h20, 32'h7fff);
		rc(8'h20, 32'h1000);
		wr(8'h20, 32'hf800);
		p(1, 16'h0800, 1'b0);
		wr(8'h40, 32'h99b);
		settle;
		rc(8'h50, 32'hfe00);
		chk({16'h0, out_value}, 32'h0);
		wr(8'h40, 32'h999);
		settle;
		chk({16'h0, out_value}, 32'h400);
		ce <= 1'b0;
		p(1, 16'h0000, 1'b0);
		settle;
		chk({16'h0, out_value}, 32'h400);
		ce <= 1'b1;
		settle;
		chk({16'h0, out_value}, 32'h0);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		settle;
		rc(8'h20, 32'h1000);
		rc(8'h00, 32'h0);
		chk({16'h0, out_min}, 32'h0);
		chk({16'h0, out_max}, 32'h1000);
		chk({16'h0, out_value}, 32'hc00);
		conclude;
	end
endmodule
